// *** hw/irs_pkg.sv ***
// Constants shared by the interrupt and status register block
// Functional notes
// [R1] Seven-bit fill count follows byte writes and reads
// [R2] Status bit 7 shows timer running
// [R3] Status bit 6 set when memory programming finished
// [R4] Status bit 5 set when checksum finished
// [R5] Status bits 2..0 give last-byte valid bits
// [R6] Secondary status reads 0x60 after reset
// [R7] Enable write: bit 7 sets or clears marked
// [R8] Enable bits 5..0 pass requests to pin
// [R9] Request write: bit 7 sets or clears marked
// [R10] Timer request set when count reaches zero
// [R11] Transmit request set on send/program/checksum done
// [R12] Receive request set when receiver terminates
// [R13] Idle request on command end, not host idle
// [R14] Fill alerts latch; cleared only by mask write
// [R15] High alert: free space at most threshold
// [R16] Low alert: fill count at most threshold
// [R17] Summary bit: any enabled request active
// [R18] Flush zeroes count and clears overflow flag, except that a write into a full FIFO in the same cycle sets it
// [R19] Count saturates at full and at empty
package irs_pkg;
  localparam int ADDR_W   = 6;
  localparam int DATA_W   = 8;
  localparam int FILL_W   = 7;
  localparam int THR_W    = 6;
  localparam int REQ_W    = 6;
  localparam int LAST_W   = 3;
  localparam int CMD_W    = 6;

  localparam logic [FILL_W-1:0] FIFO_DEPTH = 7'h40;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_FILL = 6'h04;
  localparam logic [ADDR_W-1:0] ADDR_SEC  = 6'h05;
  localparam logic [ADDR_W-1:0] ADDR_IEN  = 6'h06;
  localparam logic [ADDR_W-1:0] ADDR_IRQ  = 6'h07;

  // Field positions
  localparam int SEL_BIT   = 7;
  localparam int SEC_TIMER = 7;
  localparam int SEC_NVM   = 6;
  localparam int SEC_CRC   = 5;
  localparam int REQ_TIMER = 5;
  localparam int REQ_TX    = 4;
  localparam int REQ_RX    = 3;
  localparam int REQ_IDLE  = 2;
  localparam int REQ_HIGH  = 1;
  localparam int REQ_LOW   = 0;

  // Reset values
  localparam logic [FILL_W-1:0] FILL_RST = 7'h00;
  localparam logic [DATA_W-1:0] SEC_RST  = 8'h60;
  localparam logic [REQ_W-1:0]  IEN_RST  = 6'h00;
  localparam logic [REQ_W-1:0]  IRQ_RST  = 6'h00;
  localparam logic [DATA_W-1:0] RD_ZERO  = 8'h00;

  // Command code of the idle command
  localparam logic [CMD_W-1:0] CMD_IDLE = 6'h00;
endpackage

// *** hw/irs_mreg_if.sv ***
// Carrier between the top and a set/clear-with-mask register
interface irs_mreg_if #(
  parameter int W = 6
);
  logic                          wr;
  logic [irs_pkg::DATA_W-1:0]    wdata;
  logic [W-1:0]                  hw_set;
  logic [W-1:0]                  value;

  modport store (input wr, input wdata, input hw_set, output value);
  modport owner (output wr, output wdata, output hw_set, input value);
endinterface

// *** hw/irs_mask_reg.sv ***
// Register bank written by set/clear-with-mask, with hardware set inputs
module irs_mask_reg #(
  parameter int         W       = 6,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  irs_mreg_if.store port
);
  logic [W-1:0] val_q;
  logic [W-1:0] val_d;
  logic [W-1:0] mark;

  // Mask write, then hardware sets, so a set wins over a clear
  always_comb begin
    mark  = port.wdata[W-1:0];
    val_d = val_q;
    if (port.wr && port.wdata[irs_pkg::SEL_BIT]) begin
      val_d = val_q | mark; // R7 R9
    end else if (port.wr) begin
      val_d = val_q & ~mark; // R7 R9
    end
    val_d = val_d | port.hw_set;
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      val_q <= RST_VAL;
    end else if (ce) begin
      val_q <= val_d;
    end
  end

  assign port.value = val_q;
endmodule

// *** hw/irs_top.sv ***
// FIFO fill counter, secondary status and interrupt enable/request logic
module irs_top #(
  parameter bit IRQ_ACTIVE_HIGH = 1'b1
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  // Register port from the host interface logic
  input  wire logic [irs_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [irs_pkg::DATA_W-1:0]    reg_wdata,
  output logic      [irs_pkg::DATA_W-1:0]    reg_rdata_q,
  // FIFO activity
  input  wire logic                          fifo_wr_stb,
  input  wire logic                          fifo_rd_stb,
  input  wire logic                          fifo_clear_cmd,
  input  wire logic [irs_pkg::THR_W-1:0]     fifo_threshold,
  // Timer
  input  wire logic                          timer_running,
  input  wire logic [irs_pkg::DATA_W-1:0]    timer_count_value,
  // Other units
  input  wire logic                          nvm_busy,
  input  wire logic                          checksum_busy,
  input  wire logic [irs_pkg::LAST_W-1:0]    last_byte_valid_bits,
  input  wire logic                          tx_sent_evt,
  input  wire logic                          nvm_prog_done_evt,
  input  wire logic                          checksum_done_evt,
  input  wire logic                          rx_active,
  input  wire logic [irs_pkg::CMD_W-1:0]     cmd_code,
  input  wire logic                          host_cmd_wr,
  input  wire logic                          cmd_unknown_evt,
  // Outputs
  output logic      [irs_pkg::FILL_W-1:0]    fifo_byte_count_q,
  output logic                               fifo_overflow_flag_q,
  output logic                               fill_high_status_q,
  output logic                               fill_low_status_q,
  output logic                               irq_status_q,
  output logic                               irq_pin_q
);

  // ------------------------------------------------------------
  // Fill counter and overflow flag
  // ------------------------------------------------------------
  logic [irs_pkg::FILL_W-1:0] cnt_d;
  logic                       ovf_d;
  logic                       cnt_up;
  logic                       cnt_dn;

  // Saturating up/down count; a flush overrides both strobes
  always_comb begin
    cnt_dn = fifo_rd_stb && (fifo_byte_count_q != '0); // R19
    cnt_up = fifo_wr_stb &&
             ((fifo_byte_count_q != irs_pkg::FIFO_DEPTH) || cnt_dn); // R19
    cnt_d  = fifo_byte_count_q;
    ovf_d  = fifo_overflow_flag_q;
    if (fifo_clear_cmd) begin
      cnt_d = irs_pkg::FILL_RST; // R18
      ovf_d = 1'b0; // R18
    end else if (cnt_up && !cnt_dn) begin
      cnt_d = fifo_byte_count_q + 7'h01; // R1
    end else if (cnt_dn && !cnt_up) begin
      cnt_d = fifo_byte_count_q - 7'h01; // R1
    end
    // Write into a full FIFO; the set wins over a flush
    if (fifo_wr_stb && !cnt_up) begin
      ovf_d = 1'b1;
    end
  end

  // Counter registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fifo_byte_count_q    <= irs_pkg::FILL_RST;
      fifo_overflow_flag_q <= 1'b0;
    end else if (ce) begin
      fifo_byte_count_q    <= cnt_d;
      fifo_overflow_flag_q <= ovf_d;
    end
  end

  // ------------------------------------------------------------
  // Fill alerts
  // ------------------------------------------------------------
  logic                       high_d;
  logic                       low_d;
  logic [irs_pkg::FILL_W-1:0] free_space;
  logic [irs_pkg::FILL_W-1:0] thr_ext;

  // Compare free space and fill against the threshold
  always_comb begin
    thr_ext    = {1'b0, fifo_threshold};
    free_space = irs_pkg::FIFO_DEPTH - fifo_byte_count_q;
    high_d     = (free_space <= thr_ext); // R15
    low_d      = (fifo_byte_count_q <= thr_ext); // R16
  end

  // Alert status registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fill_high_status_q <= 1'b0;
      fill_low_status_q  <= 1'b1;
    end else if (ce) begin
      fill_high_status_q <= high_d;
      fill_low_status_q  <= low_d;
    end
  end

  // ------------------------------------------------------------
  // Secondary status
  // ------------------------------------------------------------
  logic [irs_pkg::DATA_W-1:0] sec_q;
  logic [irs_pkg::DATA_W-1:0] sec_d;

  // Assemble the status byte; bits 4 and 3 stay zero
  always_comb begin
    sec_d                    = irs_pkg::RD_ZERO;
    sec_d[irs_pkg::SEC_TIMER] = timer_running; // R2
    sec_d[irs_pkg::SEC_NVM]   = !nvm_busy; // R3
    sec_d[irs_pkg::SEC_CRC]   = !checksum_busy; // R4
    sec_d[irs_pkg::LAST_W-1:0] = last_byte_valid_bits; // R5
  end

  // Status register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_q <= irs_pkg::SEC_RST; // R6
    end else if (ce) begin
      sec_q <= sec_d;
    end
  end

  // ------------------------------------------------------------
  // Event detection
  // ------------------------------------------------------------
  logic                     tzero_prev_q;
  logic                     tzero_prev_d;
  logic                     rx_prev_q;
  logic                     rx_prev_d;
  logic                     busy_prev_q;
  logic                     busy_prev_d;
  logic                     high_prev_q;
  logic                     low_prev_q;
  logic [irs_pkg::REQ_W-1:0] req_set;
  logic                     tzero_now;
  logic                     cmd_busy_now;

  // Turn level edges into one-cycle request sets; event strobes pass straight through
  always_comb begin
    tzero_now    = (timer_count_value == irs_pkg::RD_ZERO);
    cmd_busy_now = (cmd_code != irs_pkg::CMD_IDLE);
    tzero_prev_d = tzero_now;
    rx_prev_d    = rx_active;
    busy_prev_d  = cmd_busy_now;
    req_set      = '0;
    req_set[irs_pkg::REQ_TIMER] = tzero_now && !tzero_prev_q; // R10
    req_set[irs_pkg::REQ_TX]    = tx_sent_evt || nvm_prog_done_evt ||
                                  checksum_done_evt; // R11
    req_set[irs_pkg::REQ_RX]    = rx_prev_q && !rx_active; // R12
    req_set[irs_pkg::REQ_IDLE]  = (busy_prev_q && !cmd_busy_now && !host_cmd_wr) ||
                                  cmd_unknown_evt; // R13
    req_set[irs_pkg::REQ_HIGH]  = fill_high_status_q && !high_prev_q; // R14
    req_set[irs_pkg::REQ_LOW]   = fill_low_status_q && !low_prev_q; // R14
  end

  // Previous-level registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tzero_prev_q <= 1'b1;
      rx_prev_q    <= 1'b0;
      busy_prev_q  <= 1'b0;
      high_prev_q  <= 1'b0;
      low_prev_q   <= 1'b1; // Matches low status reset, no false edge
    end else if (ce) begin
      tzero_prev_q <= tzero_prev_d;
      rx_prev_q    <= rx_prev_d;
      busy_prev_q  <= busy_prev_d;
      high_prev_q  <= fill_high_status_q;
      low_prev_q   <= fill_low_status_q;
    end
  end

  // ------------------------------------------------------------
  // Enable and request registers
  // ------------------------------------------------------------
  irs_mreg_if #(.W(irs_pkg::REQ_W)) ien_bus ();
  irs_mreg_if #(.W(irs_pkg::REQ_W)) irq_bus ();

  // Decode host writes to the two mask registers
  assign ien_bus.wr     = reg_wr && (reg_addr == irs_pkg::ADDR_IEN); // R7
  assign ien_bus.wdata  = reg_wdata;
  assign ien_bus.hw_set = '0;
  assign irq_bus.wr     = reg_wr && (reg_addr == irs_pkg::ADDR_IRQ); // R9
  assign irq_bus.wdata  = reg_wdata;
  assign irq_bus.hw_set = req_set;

  irs_mask_reg #(
    .W       (irs_pkg::REQ_W),
    .RST_VAL (irs_pkg::IEN_RST)
  ) u_ien (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .port (ien_bus)
  );

  irs_mask_reg #(
    .W       (irs_pkg::REQ_W),
    .RST_VAL (irs_pkg::IRQ_RST)
  ) u_irq (
    .clk  (clk),
    .rst  (rst),
    .ce   (ce),
    .port (irq_bus)
  );

  // ------------------------------------------------------------
  // Interrupt outputs
  // ------------------------------------------------------------
  logic irq_any;
  logic pin_d;

  // Enabled requests form the summary and the pin level
  always_comb begin
    irq_any = |(ien_bus.value & irq_bus.value); // R8 R17
    pin_d   = IRQ_ACTIVE_HIGH ? irq_any : !irq_any; // R8
  end

  // Interrupt output registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_status_q <= 1'b0;
      irq_pin_q    <= !IRQ_ACTIVE_HIGH;
    end else if (ce) begin
      irq_status_q <= irq_any; // R17
      irq_pin_q    <= pin_d;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  logic [irs_pkg::DATA_W-1:0] rdata_d;

  // Read multiplexer; unmapped offsets and select bits read zero
  always_comb begin
    rdata_d = reg_rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        irs_pkg::ADDR_FILL: rdata_d = {1'b0, fifo_byte_count_q}; // R1
        irs_pkg::ADDR_SEC:  rdata_d = sec_q;
        irs_pkg::ADDR_IEN:  rdata_d = {2'b00, ien_bus.value};
        irs_pkg::ADDR_IRQ:  rdata_d = {2'b00, irq_bus.value};
        default:            rdata_d = irs_pkg::RD_ZERO;
      endcase
    end
  end

  // Read data register, held until the next read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= irs_pkg::RD_ZERO;
    end else if (ce) begin
      reg_rdata_q <= rdata_d;
    end
  end

endmodule

// *** test/irs_top_asserts.sv ***
// Port-level checks for the interrupt and status register block
module irs_top_asserts #(
  parameter bit IRQ_ACTIVE_HIGH = 1'b1
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic [5:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic       fifo_wr_stb,
  input wire logic       fifo_rd_stb,
  input wire logic       fifo_clear_cmd,
  input wire logic [5:0] fifo_threshold,
  input wire logic [7:0] reg_rdata_q,
  input wire logic [6:0] fifo_byte_count_q,
  input wire logic       fifo_overflow_flag_q,
  input wire logic       fill_high_status_q,
  input wire logic       fill_low_status_q,
  input wire logic       irq_status_q,
  input wire logic       irq_pin_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Count steps and limits
  property p_cnt_up;
    ce && fifo_wr_stb && !fifo_rd_stb && !fifo_clear_cmd && fifo_byte_count_q < 7'h40
      |=> fifo_byte_count_q == $past(fifo_byte_count_q) + 7'h01;
  endproperty
  property p_cnt_dn;
    ce && fifo_rd_stb && !fifo_wr_stb && !fifo_clear_cmd && fifo_byte_count_q != 7'h00
      |=> fifo_byte_count_q == $past(fifo_byte_count_q) - 7'h01;
  endproperty
  property p_full;
    ce && fifo_wr_stb && !fifo_rd_stb && !fifo_clear_cmd && fifo_byte_count_q == 7'h40
      |=> fifo_byte_count_q == 7'h40 && fifo_overflow_flag_q;
  endproperty
  property p_empty;
    ce && fifo_rd_stb && !fifo_wr_stb && fifo_byte_count_q == 7'h00 |=> fifo_byte_count_q == 7'h00;
  endproperty
  property p_flush;
    ce && fifo_clear_cmd && !fifo_wr_stb |=> fifo_byte_count_q == 7'h00 && !fifo_overflow_flag_q;
  endproperty
  // Alert levels follow the count one edge later
  property p_high;
    ce |=> fill_high_status_q ==
      ((7'h40 - $past(fifo_byte_count_q)) <= {1'b0, $past(fifo_threshold)});
  endproperty
  property p_low;
    ce |=> fill_low_status_q == ($past(fifo_byte_count_q) <= {1'b0, $past(fifo_threshold)});
  endproperty
  property p_pin;
    irq_pin_q == (IRQ_ACTIVE_HIGH ? irq_status_q : !irq_status_q);
  endproperty
  property p_fill_rd;
    ce && reg_rd && reg_addr == 6'h04 |=> reg_rdata_q == {1'b0, $past(fifo_byte_count_q)};
  endproperty
  a_cnt_up: assert property (p_cnt_up) else $error("count did not step up");
  a_cnt_dn: assert property (p_cnt_dn) else $error("count did not step down");
  a_full: assert property (p_full) else $error("write at full mishandled");
  a_empty: assert property (p_empty) else $error("read at empty moved count");
  a_flush: assert property (p_flush) else $error("flush left count or overflow");
  a_high: assert property (p_high) else $error("high alert level wrong");
  a_low: assert property (p_low) else $error("low alert level wrong");
  a_pin: assert property (p_pin) else $error("irq pin disagrees with summary");
  a_fill_rd: assert property (p_fill_rd) else $error("fill count read wrong");
  c_ovf: cover property ($rose(fifo_overflow_flag_q));
  c_irq: cover property ($rose(irq_status_q));
  c_high: cover property ($rose(fill_high_status_q));
endmodule
bind irs_top irs_top_asserts #(.IRQ_ACTIVE_HIGH(IRQ_ACTIVE_HIGH)) u_asserts (
  .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .fifo_wr_stb(fifo_wr_stb), .fifo_rd_stb(fifo_rd_stb), .fifo_clear_cmd(fifo_clear_cmd),
  .fifo_threshold(fifo_threshold), .reg_rdata_q(reg_rdata_q),
  .fifo_byte_count_q(fifo_byte_count_q), .fifo_overflow_flag_q(fifo_overflow_flag_q),
  .fill_high_status_q(fill_high_status_q), .fill_low_status_q(fill_low_status_q),
  .irq_status_q(irq_status_q), .irq_pin_q(irq_pin_q));

// *** test/irs_host_model.sv ***
// Behavioural host processor on the register port
module irs_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata_q,
  output logic      [5:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    reg_addr = 6'h3F;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // One write; bit 7 of the data picks set or clear on mask registers
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask
  // One read; data taken after the strobe edge
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rdata_q;
  endtask
endmodule

// *** test/irs_top_bench.sv ***
// Self-checking bench for the interrupt and status register block
module irs_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0, rst = 1'b1, ce = 1'b1, trun = 1'b0, nvmb = 1'b0, ckb = 1'b0;
  logic       tx = 1'b0, nvd = 1'b0, ckd = 1'b0, rxa = 1'b1, hcw = 1'b0, unk = 1'b0;
  logic [2:0] fst = 3'h0, lastb = 3'h0;
  logic [7:0] tcnt = 8'h01, d, wdata, rdata;
  logic [5:0] cmd = 6'h05, thr = 6'h04, addr;
  logic       wr, rd, ovf, hi, lo, irqs, pin;
  logic [6:0] cnt;
  logic [5:0] evt_exp [8] = '{6'h20, 6'h10, 6'h10, 6'h10, 6'h08, 6'h04, 6'h04, 6'h00};
  int         err_count = 0, checks_done = 0;
  always #50 clk = ~clk;
  irs_host_model i_host (.clk(clk), .reg_rdata_q(rdata), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wdata));
  irs_top i_dut (.clk(clk), .rst(rst), .ce(ce), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdata), .reg_rdata_q(rdata), .fifo_wr_stb(fst[0]), .fifo_rd_stb(fst[1]),
    .fifo_clear_cmd(fst[2]), .fifo_threshold(thr), .timer_running(trun),
    .timer_count_value(tcnt), .nvm_busy(nvmb), .checksum_busy(ckb),
    .last_byte_valid_bits(lastb), .tx_sent_evt(tx), .nvm_prog_done_evt(nvd),
    .checksum_done_evt(ckd), .rx_active(rxa), .cmd_code(cmd), .host_cmd_wr(hcw),
    .cmd_unknown_evt(unk), .fifo_byte_count_q(cnt), .fifo_overflow_flag_q(ovf),
    .fill_high_status_q(hi), .fill_low_status_q(lo), .irq_status_q(irqs), .irq_pin_q(pin));
  // Compare and count
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e, input string n);
    i_host.rd(a, d);
    chk(n, e, d);
  endtask
  // FIFO strobes for n cycles, then one settling edge
  task automatic st(input logic [2:0] v, input int n);
    fst = v;
    repeat (n) @(negedge clk);
    fst = 3'h0;
    @(negedge clk);
  endtask
  // One event source per index
  task automatic pulse(input int k);
    tcnt = 8'h01;
    rxa = 1'b1;
    cmd = 6'h05;
    @(negedge clk);
    case (k)
      0: tcnt = 8'h00;
      1: tx = 1'b1;
      2: nvd = 1'b1;
      3: ckd = 1'b1;
      4: rxa = 1'b0;
      5: cmd = 6'h00;
      6: unk = 1'b1;
      default: {cmd, hcw} = 7'h01;
    endcase
    @(negedge clk);
    {tx, nvd, ckd, unk, hcw} = 5'h00;
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rc(6'h04, 8'h00, "fill_count");
    rc(6'h05, 8'h60, "secondary_flags");
    rc(6'h06, 8'h00, "irq_enable_mask");
    rc(6'h07, 8'h00, "irq_request_flags");
    rc(6'h2A, 8'h00, "unmapped");
    i_host.wr(6'h04, 8'hFF);
    rc(6'h04, 8'h00, "fill_count_ro");
    i_host.wr(6'h06, 8'hBF);
    rc(6'h06, 8'h3F, "enable_set");
    i_host.wr(6'h06, 8'h15);
    rc(6'h06, 8'h2A, "enable_clear");
    i_host.wr(6'h07, 8'h88);
    // Summary and pin follow the request flag one edge later
    @(negedge clk);
    chk("irq_pin_on", 8'h01, {7'h00, pin});
    chk("irq_status_on", 8'h01, {7'h00, irqs});
    i_host.wr(6'h06, 8'h08);
    @(negedge clk);
    chk("irq_pin_masked", 8'h00, {7'h00, pin});
    chk("irq_status_masked", 8'h00, {7'h00, irqs});
    i_host.wr(6'h07, 8'hBF);
    rc(6'h07, 8'h3F, "request_set");
    i_host.wr(6'h07, 8'h3F);
    rc(6'h07, 8'h00, "request_clear");
    {trun, nvmb, ckb, lastb} = 6'h3D;
    rc(6'h05, 8'h85, "status_busy");
    {trun, nvmb, ckb, lastb} = 6'h0B;
    rc(6'h05, 8'h43, "status_done");
    i_host.wr(6'h06, 8'hBF);
    for (int k = 0; k < 8; k++) begin
      pulse(k);
      rc(6'h07, {2'b00, evt_exp[k]}, "event_request");
      chk("event_pin", {7'h00, |evt_exp[k]}, {7'h00, pin});
      chk("event_status", {7'h00, |evt_exp[k]}, {7'h00, irqs});
      i_host.wr(6'h07, 8'h3F);
    end
    st(3'h1, 65);
    chk("count_full", 8'h40, {1'b0, cnt});
    chk("overflow", 8'h01, {7'h00, ovf});
    rc(6'h07, 8'h02, "high_request");
    st(3'h2, 4);
    chk("high_at_60", 8'h01, {7'h00, hi});
    st(3'h2, 1);
    chk("high_at_59", 8'h00, {7'h00, hi});
    rc(6'h07, 8'h02, "high_latched");
    st(3'h4, 1);
    chk("flush", 8'h00, {cnt, ovf});
    rc(6'h07, 8'h03, "low_request");
    st(3'h2, 1);
    chk("count_empty", 8'h00, {1'b0, cnt});
    // Clock enable low freezes the count
    ce = 1'b0;
    st(3'h1, 2);
    chk("ce_freeze", 8'h00, {1'b0, cnt});
    ce = 1'b1;
    st(3'h1, 5);
    chk("low_at_5", 8'h00, {7'h00, lo});
    st(3'h2, 1);
    chk("low_at_4", 8'h01, {7'h00, lo});
    i_host.wr(6'h07, 8'h03);
    rc(6'h07, 8'h00, "alert_clear");
    end_sim;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("FAIL watchdog expected end seen hang");
    end_sim;
  end
endmodule
